// >>> shared/loop_detect_defs.vh
// Constants for the loop detect timer: register addresses, fields, resets.
// Assumes an 8-bit memory bus with a 16-bit byte address.
`ifndef LOOP_DETECT_DEFS_VH
`define LOOP_DETECT_DEFS_VH
`define MODE_REG_ADDR 16'hff98
`define KICK_REG_ADDR 16'hff99
`define MODE_REG_RESET 8'h67
`define MODE_FIXED_BITS 3'h3
`define KICK_VALUE 8'hac
`define KICK_READ_VALUE 8'h9a
`define STOP_SELECT_BIT 4
`define SOURCE_SELECT_BIT 3
`define PERIOD_MSB 2
`define PERIOD_LSB 0
`define CAUSE_FLAG_BIT 4
`define OSC_BASE_EXP 5'd11
`define HS_BASE_EXP 5'd13
`define COUNTER_WIDTH 21
`endif

// >>> rtl/overflow_counter.v
// Free counter for the loop detect timer with a selectable overflow power.
// Assumes count_en is a one-cycle enable from the chosen source clock.
`timescale 1ns/100ps
`default_nettype none
module overflow_counter #(
    parameter WIDTH = 21
) (
    input wire clk,
    input wire reset_n,
    input wire clear,
    input wire count_en,
    input wire [4:0] exponent,
    output reg overflow
);
    reg [WIDTH-1:0] count;
    wire [WIDTH-1:0] limit;

    // The overflow fires on the enabled tick that finds the count at two to the selected power less one.
    assign limit = {{(WIDTH-1){1'b0}}, 1'b1} << exponent;

    always @(posedge clk) begin
        if (!reset_n) begin
            count <= {WIDTH{1'b0}};
            overflow <= 1'b0;
        end else if (clear) begin
            count <= {WIDTH{1'b0}};
            overflow <= 1'b0;
        end else if (count_en) begin
            if (count == limit - {{(WIDTH-1){1'b0}}, 1'b1}) begin
                count <= {WIDTH{1'b0}};
                overflow <= 1'b1;
            end else begin
                count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
                overflow <= 1'b0;
            end
        end else begin
            overflow <= 1'b0;
        end
    end
endmodule // overflow_counter
`default_nettype wire

// >>> rtl/loop_detect_timer.v
// Loop detect timer with a write-once mode register and a kick register.
// Assumes an 8-bit CPU bus with one-cycle read and write strobes, clock
// enables for each source clock, and standby status inputs from the core.
//
// Notes on behaviour
// R01: Counter overflow without a kick raises the internal reset request.
// R02: A reset from this timer sets bit 4 of the reset cause register.
// R03: Oscillator source: overflow after two to the 11 through 18 cycles.
// R04: High-speed source: overflow after two to the 13 through 20 cycles.
// R05: After reset the timer counts the oscillator at the longest period.
// R06: Mode register resets to 67 hex.
// R07: Top three mode bits must be 011; fixed mode ignores other values.
// R08: Clock select: 00 oscillator, 01 high-speed, 1x stopped.
// R09: In fixed mode the clock select field is ignored.
// R10: In fixed mode nothing halts the counting.
// R11: Stoppable mode lets software pick high-speed, oscillator or stop.
// R12: Only the first mode write is taken; a second one resets.
// R13: A reset raised while the source clock is stopped waits for it.
// R14: Software writes the mode register only as a whole byte.
// R15: Reading the mode register has no side effect.
// R16: Once stopped by the stop bit the timer stays stopped, no reset.
// R17: A mode write inserts a wait cycle.
// R18: High-speed source is gated while stopped, in standby or settling.
// R19: Oscillator source is gated in standby or when software stops it.
// R20: Writing AC hex to the kick register clears and restarts the count.
// R21: Other kick values reset; the kick register reads 9A hex.
// R22: The first write to the mode register clears the counter.
// R23: The reset request is a registered pulse.
`timescale 1ns/100ps
`default_nettype none
`include "loop_detect_defs.vh"
module loop_detect_timer (
    input wire clk,
    input wire reset_n,
    input wire osc_fixed,
    input wire osc_tick,
    input wire hs_tick,
    input wire hs_stopped,
    input wire hs_settling,
    input wire standby,
    input wire osc_sw_stopped,
    input wire [15:0] bus_addr,
    input wire [7:0] bus_wdata,
    input wire bus_write,
    input wire bus_read,
    input wire bus_bit_op,
    output reg [7:0] bus_rdata,
    output reg bus_wait,
    output reg internal_reset,
    output reg watchdog_reset_cause_flag
);
    reg [7:0] watchdog_mode_register;
    reg mode_written;
    reg stopped_latch;
    reg reset_pending;
    reg clear_counter;
    reg next_pending;
    reg fire_request;
    wire mode_wr;
    wire kick_wr;
    wire watchdog_stop_select;
    wire watchdog_source_select;
    wire [2:0] period;
    wire source_gated;
    wire count_en;
    wire [4:0] exponent;
    wire overflow;
    wire bad_access;

    function [4:0] period_exp;
        input [4:0] base;
        input [2:0] sel;
        begin
            period_exp = base + {2'b00, sel};
        end
    endfunction

    assign mode_wr = bus_write && (bus_addr == `MODE_REG_ADDR);
    assign kick_wr = bus_write && (bus_addr == `KICK_REG_ADDR);
    assign watchdog_stop_select =
        watchdog_mode_register[`STOP_SELECT_BIT] && !osc_fixed; // [R09]
    assign watchdog_source_select =
        watchdog_mode_register[`SOURCE_SELECT_BIT] && !osc_fixed; // [R09]
    assign period = watchdog_mode_register[`PERIOD_MSB:`PERIOD_LSB];

    // Gating of the source clock; fixed mode never gates.
    assign source_gated = osc_fixed ? 1'b0 : // [R10]
        watchdog_source_select ? (hs_stopped || standby || hs_settling) : // [R18]
        (standby || osc_sw_stopped); // [R19]

    // Only a running, ungated, unstopped timer advances.
    assign count_en = !stopped_latch && !watchdog_stop_select && // [R08] [R16]
        !source_gated && (watchdog_source_select ? hs_tick : osc_tick); // [R11]

    assign exponent = watchdog_source_select ?
        period_exp(`HS_BASE_EXP, period) : // [R04]
        period_exp(`OSC_BASE_EXP, period); // [R03]

    // A second mode write, a bad kick value or a bit access to the kick
    // register are illegal accesses.
    assign bad_access = (mode_wr && mode_written) || // [R12]
        (kick_wr && (bus_bit_op || bus_wdata != `KICK_VALUE)); // [R21]

    overflow_counter #(
        .WIDTH(`COUNTER_WIDTH)
    ) u_counter (
        .clk(clk),
        .reset_n(reset_n),
        .clear(clear_counter),
        .count_en(count_en),
        .exponent(exponent),
        .overflow(overflow)
    );

    always @* begin
        next_pending = reset_pending;
        fire_request = 1'b0;
        if (bad_access && !stopped_latch && !watchdog_stop_select) begin
            next_pending = 1'b1; // [R12] [R21]
        end
        // A request fires at once on a running source, or waits for it.
        if (next_pending && !source_gated && !stopped_latch &&
            !watchdog_stop_select) begin
            fire_request = 1'b1; // [R13]
            next_pending = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            watchdog_mode_register <= `MODE_REG_RESET; // [R05] [R06]
            mode_written <= 1'b0;
            stopped_latch <= 1'b0;
            reset_pending <= 1'b0;
            clear_counter <= 1'b0;
            internal_reset <= 1'b0;
            bus_wait <= 1'b0;
            bus_rdata <= 8'h00;
        end else begin
            clear_counter <= 1'b0;
            bus_wait <= mode_wr; // [R17]
            if (mode_wr && !mode_written) begin
                mode_written <= 1'b1; // [R12]
                clear_counter <= 1'b1; // [R22]
                if (osc_fixed) begin
                    watchdog_mode_register <= {`MODE_FIXED_BITS, 2'b00,
                        bus_wdata[2:0]}; // [R07] [R09]
                end else begin
                    watchdog_mode_register <= bus_wdata; // [R14]
                end
                if (bus_wdata[`STOP_SELECT_BIT] && !osc_fixed) begin
                    stopped_latch <= 1'b1; // [R16]
                end
            end
            if (kick_wr && !bus_bit_op && bus_wdata == `KICK_VALUE) begin
                clear_counter <= 1'b1; // [R20]
            end
            reset_pending <= next_pending;
            // Immediate or deferred reset request, one cycle wide.
            internal_reset <= overflow || fire_request; // [R01] [R23]
            if (bus_read) begin
                if (bus_addr == `MODE_REG_ADDR) begin
                    bus_rdata <= watchdog_mode_register; // [R15]
                end else if (bus_addr == `KICK_REG_ADDR) begin
                    bus_rdata <= `KICK_READ_VALUE; // [R21]
                end else begin
                    bus_rdata <= 8'h00;
                end
            end
        end
    end

    // The cause flag survives the reset it reports; once set it stays set,
    // as this block has no input or path that clears it.
    always @(posedge clk) begin
        if (internal_reset) begin
            watchdog_reset_cause_flag <= 1'b1; // [R02]
        end else if (!reset_n) begin
            watchdog_reset_cause_flag <= watchdog_reset_cause_flag;
        end
    end

    initial begin
        watchdog_reset_cause_flag = 1'b0;
    end
endmodule // loop_detect_timer
`default_nettype wire

// >>> bench/loop_detect_asserts.sv
// Port assertions for the loop detect timer.
// Assumes the timer's header defines are on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "loop_detect_defs.vh"
module loop_detect_asserts (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic osc_fixed,
    input wire logic standby,
    input wire logic osc_sw_stopped,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    input wire logic bus_bit_op,
    input wire logic [7:0] bus_rdata,
    input wire logic bus_wait,
    input wire logic internal_reset,
    input wire logic watchdog_reset_cause_flag
);
    logic done;
    wire mw = bus_write && bus_addr == `MODE_REG_ADDR;
    wire kw = bus_write && bus_addr == `KICK_REG_ADDR;
    wire live = osc_fixed && !standby && !osc_sw_stopped;
    always @(posedge clk) begin
        if (!reset_n)
            done <= 1'b0;
        else if (mw)
            done <= 1'b1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_pulse_len: assert property (
        internal_reset[*2] |=> !internal_reset) else $error("long pulse");
    chk_cause_set: assert property (
        internal_reset |=> watchdog_reset_cause_flag) else $error("no flag");
    chk_kick_read: assert property (
        bus_read && bus_addr == `KICK_REG_ADDR |=> bus_rdata == 8'h9a)
        else $error("kick read value");
    chk_mode_wait: assert property (
        mw |=> bus_wait) else $error("no wait cycle");
    chk_bad_kick: assert property (
        kw && live && (bus_wdata != 8'hac || bus_bit_op) |=> internal_reset)
        else $error("bad kick kept quiet");
    chk_second_write: assert property (
        mw && done && live |=> internal_reset) else $error("second write");
    chk_fixed_bits: assert property (
        osc_fixed && bus_read && bus_addr == `MODE_REG_ADDR
        |=> bus_rdata[7:3] == 5'h0c) else $error("fixed bits");
    chk_rdata_hold: assert property (
        !bus_read |=> $stable(bus_rdata)) else $error("read data moved");
    cover property (internal_reset);
    cover property (mw && done);
    cover property (kw && !live);
endmodule // loop_detect_asserts
bind loop_detect_timer loop_detect_asserts loop_detect_asserts_i (
    .clk(clk), .reset_n(reset_n), .osc_fixed(osc_fixed), .standby(standby),
    .osc_sw_stopped(osc_sw_stopped), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
    .bus_bit_op(bus_bit_op), .bus_rdata(bus_rdata), .bus_wait(bus_wait),
    .internal_reset(internal_reset),
    .watchdog_reset_cause_flag(watchdog_reset_cause_flag));
`default_nettype wire

// >>> bench/loop_detect_timer_bench.sv
// Self-checking bench for the loop detect timer.
// Assumes the timer and its header; source ticks come every clock.
`timescale 1ns/100ps
`default_nettype none
`include "loop_detect_defs.vh"
module loop_detect_timer_bench;
    logic clk = 1'b0, reset_n = 1'b0, osc_fixed = 1'b1, osc_tick = 1'b1;
    logic hs_tick = 1'b0, hs_stopped = 1'b0, hs_settling = 1'b0;
    logic standby = 1'b0, osc_sw_stopped = 1'b0, bus_bit_op = 1'b0;
    logic bus_write = 1'b0, bus_read = 1'b0, wr_reset = 1'b0;
    logic [15:0] bus_addr = 16'h0000;
    logic [7:0] bus_wdata = 8'h00;
    wire [7:0] bus_rdata;
    wire bus_wait, internal_reset, watchdog_reset_cause_flag;
    int fail_count = 0, total_checks = 0;
    always #25 clk = ~clk;
    loop_detect_timer loop_detect_timer_i (.clk(clk), .reset_n(reset_n),
        .osc_fixed(osc_fixed), .osc_tick(osc_tick), .hs_tick(hs_tick),
        .hs_stopped(hs_stopped), .hs_settling(hs_settling),
        .standby(standby), .osc_sw_stopped(osc_sw_stopped),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
        .bus_read(bus_read), .bus_bit_op(bus_bit_op), .bus_rdata(bus_rdata),
        .bus_wait(bus_wait), .internal_reset(internal_reset),
        .watchdog_reset_cause_flag(watchdog_reset_cause_flag));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input b);
        bus_addr = a;
        bus_wdata = d;
        bus_bit_op = b;
        bus_write = 1'b1;
        step(1);
        bus_write = 1'b0;
        bus_bit_op = 1'b0;
        wr_reset = internal_reset;
        chk({7'h00, bus_wait}, {7'h00, a == `MODE_REG_ADDR});
        step(1);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        bus_addr = a;
        bus_read = 1'b1;
        step(1);
        bus_read = 1'b0;
        chk(bus_rdata, exp);
        step(1);
    endtask
    task automatic wait_rst(input int lo, input int hi, input logic exp);
        int n;
        n = 0;
        while (internal_reset !== 1'b1 && n < hi) begin
            step(1);
            n++;
        end
        chk(8'(n >= lo), 8'h01);
        chk({7'h00, internal_reset}, {7'h00, exp});
    endtask
    task automatic new_run(input logic f);
        reset_n = 1'b0;
        osc_fixed = f;
        step(6);
        reset_n = 1'b1;
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #2_500_000;
        fail_count++;
        finish_test();
    end
    initial begin
        new_run(1'b1);
        rd(`MODE_REG_ADDR, 8'h67);
        rd(`KICK_REG_ADDR, 8'h9a);
        rd(16'hff9a, 8'h00);
        wr(`MODE_REG_ADDR, 8'hf8, 1'b0);
        rd(`MODE_REG_ADDR, 8'h60);
        wait_rst(0, 1500, 1'b0);
        wr(`KICK_REG_ADDR, 8'hac, 1'b0);
        wait_rst(2040, 2060, 1'b1);
        step(1);
        chk({7'h00, watchdog_reset_cause_flag}, 8'h01);
        for (int i = 0; i < 3; i++) begin
            new_run(1'b1);
            wr(`MODE_REG_ADDR, 8'h60, 1'b0);
            standby = (i == 1);
            wr(i == 0 ? 16'hff98 : 16'hff99, i == 1 ? 8'h55 : 8'hac, i == 2);
            chk({7'h00, wr_reset}, 8'h01);
            wait_rst(0, 3, 1'b0);
        end
        standby = 1'b0;
        new_run(1'b0);
        wr(`MODE_REG_ADDR, 8'h70, 1'b0);
        rd(`MODE_REG_ADDR, 8'h70);
        wait_rst(0, 3000, 1'b0);
        wr(`MODE_REG_ADDR, 8'h60, 1'b0);
        wait_rst(0, 3000, 1'b0);
        new_run(1'b0);
        osc_tick = 1'b0;
        hs_tick = 1'b1;
        wr(`MODE_REG_ADDR, 8'h68, 1'b0);
        wait_rst(8180, 8200, 1'b1);
        new_run(1'b0);
        osc_tick = 1'b1;
        wr(`MODE_REG_ADDR, 8'h60, 1'b0);
        osc_sw_stopped = 1'b1;
        wr(`KICK_REG_ADDR, 8'h00, 1'b0);
        wait_rst(0, 100, 1'b0);
        osc_sw_stopped = 1'b0;
        wait_rst(0, 3, 1'b1);
        new_run(1'b0);
        wr(`MODE_REG_ADDR, 8'h68, 1'b0);
        hs_stopped = 1'b1;
        wr(`KICK_REG_ADDR, 8'h55, 1'b0);
        wait_rst(0, 100, 1'b0);
        hs_stopped = 1'b0;
        wait_rst(0, 3, 1'b1);
        finish_test();
    end
endmodule // loop_detect_timer_bench
`default_nettype wire
